// ### inc/vdoc_defines.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes a 25 MHz processing clock and APB byte addresses.
`ifndef VDOC_DEFINES_SVH
`define VDOC_DEFINES_SVH
`define OFS_CTRL      12'h000
`define OFS_SET       12'h004
`define OFS_KFAC      12'h008
`define OFS_VCTL      12'h00C
`define OFS_VUP       12'h010
`define OFS_VLOW      12'h014
`define OFS_TMS       12'h018
`define OFS_DT        12'h01C
`define OFS_HOLD      12'h020
`define OFS_STATUS    12'h024
`define OFS_IRQ_STAT  12'h028
`define OFS_IRQ_EN    12'h02C
`define OFS_IRQ_CLR   12'h030
`define CTRL_MODE_LSB 0
`define CTRL_IDMT     2
`define CTRL_DLY_RST  3
`define CTRL_XF_LSB   4
`define CTRL_ENABLE   6
`define CTRL_RST      8'h00
`define SET_RST       16'h0400
`define KFAC_RST      8'h80
`define VCTL_RST      16'h8000
`define VUP_RST       16'hC000
`define VLOW_RST      16'h4000
`define TMS_RST       16'h0064
`define DT_RST        16'h03E8
`define HOLD_RST      16'h0000
`define CLK_NS        40
`define TICK_NS       1000000
`define TICK_CYCLES   ((`TICK_NS) / (`CLK_NS))
`define PROG_FULL     32'h8000_0000
// Full scale times ln(2) over (70 * 256): per-tick gain for TMS in hundredths.
`define IDMT_GAIN     32'h0001_447A
`endif

// ### inc/vdoc_pkg.sv
// Types shared by the voltage-dependent overcurrent element.
// Assumes nothing beyond the defines header.
`default_nettype none
package vdoc_pkg;
    typedef enum logic [1:0] {MODE_PLAIN, MODE_VCTRL, MODE_VRESTR} mode_type;
    typedef enum logic [1:0] {XF_OFF, XF_YD1, XF_YD11} xform_type;
endpackage
`default_nettype wire

// ### src/voltage_dependent_overcurrent.sv
// Three-phase voltage-dependent overcurrent element with APB registers.
// Assumes current and voltage magnitudes arrive each clock from logic on I_REF_CLK.
// Summary of operation
// R1: Mode selects plain, voltage-controlled or voltage-restrained pickup.
// R2: Operate delay is definite time or standard inverse per control bit.
// R3: Timer resets instantly or after a hold time, per control bit.
// R4: Plain mode pickup equals the current setting at any voltage.
// R5: Controlled mode pickup steps to factor times setting below control voltage.
// R6: The low-voltage factor scales the setting to give the reduced pickup.
// R7: Restrained mode pickup falls progressively between upper and lower voltage.
// R8: Restrained mode pickup stays at factor-scaled value below lower voltage.
// R9: Restrained pickup between levels is computed arithmetically from the voltage.
// R10: That computation is a linear interpolation between both pickups.
// R11: Each phase uses one phase-phase voltage; phase A uses A-B.
// R12: Phase B uses B-C and phase C uses C-A.
// R13: Optional transform gives step-up high-side voltages for two vector groups.
// R14: Below pickup, progress is held for the hold time and then cleared.
// R15: External block input inhibits operation for time grading.
// R16: Inverse time is TMS times 0.14 over ratio power 0.02 minus one.
// R17: Trip asserts when timer completes while above pickup and unblocked.
`timescale 1ns/1ps
`default_nettype none
`include "vdoc_defines.svh"
module voltage_dependent_overcurrent #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    input  wire logic [15:0] I_IA,
    input  wire logic [15:0] I_IB,
    input  wire logic [15:0] I_IC,
    input  wire logic [15:0] I_VAB,
    input  wire logic [15:0] I_VBC,
    input  wire logic [15:0] I_VCA,
    input  wire logic        I_BLOCK,
    output logic             O_PREADY,
    output logic      [31:0] O_PRDATA,
    output logic             O_PSLVERR,
    output logic       [2:0] O_TRIP_PH,
    output logic             O_TRIP,
    output logic             O_START,
    output logic             O_IRQ
);
    logic [7:0]  ctrl_reg;
    logic [15:0] set_reg;
    logic [7:0]  kfac_reg;
    logic [15:0] vctl_reg;
    logic [15:0] vup_reg;
    logic [15:0] vlow_reg;
    logic [15:0] tms_reg;
    logic [15:0] dt_reg;
    logic [15:0] hold_ms_reg;
    logic [3:0]  irq_en_reg;
    logic [3:0]  irq_stat_reg;
    logic [3:0]  irq_stat_next;
    logic [3:0]  irq_ev;
    logic        blk_s1_reg;
    logic        blk_s2_reg;
    logic [15:0] tick_cnt_reg;
    logic        tick_reg;
    logic [31:0] prog_reg [3];
    logic [31:0] prog_next [3];
    logic [15:0] hcnt_reg [3];
    logic [15:0] hcnt_next [3];
    logic [2:0]  trip_reg;
    logic [2:0]  trip_next;
    logic [2:0]  start_reg;
    logic [15:0] cur [3];
    logic [15:0] vmeas [3];
    logic [15:0] vsel [3];
    logic [15:0] pick [3];
    logic [15:0] ratio [3];
    logic [11:0] lg [3];
    logic [31:0] inc [3];
    logic [2:0]  above;

    // Divides with a zero divisor giving full scale.
    function automatic logic [31:0] f_div(input logic [31:0] n, input logic [31:0] d);
        f_div = (d == 32'h0000_0000) ? 32'hFFFF_FFFF : n / d;
    endfunction

    // Approximate base-2 logarithm of a ratio in 8.8 fixed point, zero at or below one.
    function automatic logic [11:0] f_log2q8(input logic [15:0] r);
        logic [3:0]  p;
        logic [15:0] s;
        p = 4'h0;
        for (int b = 0; b < 16; b++) begin
            if (r[b]) begin
                p = 4'(b);
            end
        end
        s = r << (4'hF - p);
        f_log2q8 = (r <= 16'h0100) ? 12'h000 : {p - 4'h8, s[14:7]};
    endfunction

    // Mean of two voltage magnitudes.
    function automatic logic [15:0] f_avg(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        f_avg = s[16:1];
    endfunction

    // Effective pickup for one phase from mode, voltage and settings.
    function automatic logic [15:0] f_pickup(input vdoc_pkg::mode_type m, input logic [15:0] v,
                                             input logic [15:0] s, input logic [15:0] ks,
                                             input logic [15:0] vs, input logic [15:0] vu,
                                             input logic [15:0] vl);
        logic [31:0] num;
        num = 32'(s - ks) * 32'(v - vl);
        case (m)
            vdoc_pkg::MODE_VCTRL: f_pickup = (v < vs) ? ks : s; // R5
            vdoc_pkg::MODE_VRESTR: begin
                if (v >= vu) begin
                    f_pickup = s;
                end else if (v <= vl) begin
                    f_pickup = ks; // R8
                end else begin
                    f_pickup = ks + 16'(f_div(num, 32'(vu - vl))); // R7 R9 R10
                end
            end
            default: f_pickup = s; // R4
        endcase
    endfunction

    // APB decoding and read selection.
    wire        acc       = I_PSEL & I_PENABLE & O_PREADY;
    wire        wr        = acc & I_PWRITE;
    wire        hit_ctrl  = (I_PADDR == `OFS_CTRL);
    wire        hit_set   = (I_PADDR == `OFS_SET);
    wire        hit_kfac  = (I_PADDR == `OFS_KFAC);
    wire        hit_vctl  = (I_PADDR == `OFS_VCTL);
    wire        hit_vup   = (I_PADDR == `OFS_VUP);
    wire        hit_vlow  = (I_PADDR == `OFS_VLOW);
    wire        hit_tms   = (I_PADDR == `OFS_TMS);
    wire        hit_dt    = (I_PADDR == `OFS_DT);
    wire        hit_hold  = (I_PADDR == `OFS_HOLD);
    wire        hit_stat  = (I_PADDR == `OFS_STATUS);
    wire        hit_istat = (I_PADDR == `OFS_IRQ_STAT);
    wire        hit_ien   = (I_PADDR == `OFS_IRQ_EN);
    wire        hit_iclr  = (I_PADDR == `OFS_IRQ_CLR);
    wire        mapped    = hit_ctrl | hit_set | hit_kfac | hit_vctl | hit_vup | hit_vlow | hit_tms
                            | hit_dt | hit_hold | hit_stat | hit_istat | hit_ien | hit_iclr;
    wire [31:0] rd_data   = hit_ctrl  ? {24'h00_0000, ctrl_reg} :
                            hit_set   ? {16'h0000, set_reg} :
                            hit_kfac  ? {24'h00_0000, kfac_reg} :
                            hit_vctl  ? {16'h0000, vctl_reg} :
                            hit_vup   ? {16'h0000, vup_reg} :
                            hit_vlow  ? {16'h0000, vlow_reg} :
                            hit_tms   ? {16'h0000, tms_reg} :
                            hit_dt    ? {16'h0000, dt_reg} :
                            hit_hold  ? {16'h0000, hold_ms_reg} :
                            hit_stat  ? {25'h000_0000, blk_s2_reg, trip_reg, start_reg} :
                            hit_istat ? {28'h000_0000, irq_stat_reg} :
                            hit_ien   ? {28'h000_0000, irq_en_reg} : 32'h0000_0000;

    // Control fields and shared timer increments.
    wire vdoc_pkg::mode_type  mode = vdoc_pkg::mode_type'(ctrl_reg[`CTRL_MODE_LSB +: 2]); // R1
    wire vdoc_pkg::xform_type xf   = vdoc_pkg::xform_type'(ctrl_reg[`CTRL_XF_LSB +: 2]);
    wire        idmt      = ctrl_reg[`CTRL_IDMT]; // R2
    wire        dly_rst   = ctrl_reg[`CTRL_DLY_RST]; // R3
    wire        enable    = ctrl_reg[`CTRL_ENABLE];
    wire [23:0] kprod     = 24'(set_reg) * 24'(kfac_reg);
    wire [15:0] kset      = kprod[23:8]; // R6
    // Rounded up so that the set number of ticks always reaches full scale.
    wire [31:0] dt_inc    = f_div(`PROG_FULL + 32'(dt_reg) - 32'h0000_0001, 32'(dt_reg)); // R2
    wire [31:0] idmt_unit = f_div(`IDMT_GAIN << 8, 32'(tms_reg)); // R16
    wire        blocked   = blk_s2_reg | ~enable; // R15

    assign cur[0]   = I_IA;
    assign cur[1]   = I_IB;
    assign cur[2]   = I_IC;
    assign vmeas[0] = I_VAB; // R11
    assign vmeas[1] = I_VBC; // R12
    assign vmeas[2] = I_VCA; // R12

    // Per-phase voltage choice, pickup and timer increment.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            case (xf)
                vdoc_pkg::XF_YD1:  vsel[i] = f_avg(vmeas[i], vmeas[(i + 2) % 3]); // R13
                vdoc_pkg::XF_YD11: vsel[i] = f_avg(vmeas[i], vmeas[(i + 1) % 3]); // R13
                default:           vsel[i] = vmeas[i];
            endcase
            pick[i]  = f_pickup(mode, vsel[i], set_reg, kset, vctl_reg, vup_reg, vlow_reg);
            above[i] = cur[i] > pick[i];
            ratio[i] = 16'(f_div({8'h00, cur[i], 8'h00}, 32'(pick[i])));
            if (f_div({8'h00, cur[i], 8'h00}, 32'(pick[i])) > 32'h0000_FFFF) begin
                ratio[i] = 16'hFFFF;
            end
            lg[i]  = f_log2q8(ratio[i]);
            inc[i] = idmt ? 32'((44'(lg[i]) * 44'(idmt_unit)) >> 8) : dt_inc; // R2 R16
        end
    end

    // Timer progress, hold and trip decisions per phase.
    always_comb begin
        logic [32:0] sum;
        sum = 33'h0_0000_0000;
        for (int i = 0; i < 3; i++) begin
            prog_next[i] = prog_reg[i];
            hcnt_next[i] = hcnt_reg[i];
            sum          = {1'b0, prog_reg[i]} + {1'b0, inc[i]};
            trip_next[i] = above[i] & ~blocked & (prog_reg[i] >= `PROG_FULL); // R17
            if (blocked) begin
                prog_next[i] = 32'h0000_0000; // R15
                hcnt_next[i] = 16'h0000;
            end else if (above[i]) begin
                hcnt_next[i] = 16'h0000;
                if (tick_reg) begin
                    prog_next[i] = (sum >= 33'(`PROG_FULL)) ? `PROG_FULL : sum[31:0];
                end
            end else if (!dly_rst || hcnt_reg[i] >= hold_ms_reg) begin
                prog_next[i] = 32'h0000_0000; // R3
                hcnt_next[i] = 16'h0000;
            end else if (tick_reg && prog_reg[i] != 32'h0000_0000) begin
                hcnt_next[i] = hcnt_reg[i] + 16'h0001; // R14
            end
        end
    end

    // Interrupt events: phase trips rising and any start rising.
    assign irq_ev        = {(|(above & ~{3{blocked}})) & ~(|start_reg), trip_next & ~trip_reg};
    assign irq_stat_next = irq_ev | (irq_stat_reg & ~((wr & hit_iclr) ? I_PWDATA[3:0] : 4'h0));

    // Block pin synchroniser and millisecond tick.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            blk_s1_reg   <= 1'b0;
            blk_s2_reg   <= 1'b0;
            tick_cnt_reg <= 16'h0000;
            tick_reg     <= 1'b0;
        end else begin
            blk_s1_reg   <= I_BLOCK;
            blk_s2_reg   <= blk_s1_reg;
            tick_reg     <= (tick_cnt_reg == 16'(TICK_CYCLES - 1));
            tick_cnt_reg <= (tick_cnt_reg == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt_reg + 16'h0001;
        end
    end

    // APB answer one cycle into the access phase.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_PREADY  <= 1'b0;
            O_PRDATA  <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY  <= I_PSEL & I_PENABLE & ~O_PREADY;
            O_PRDATA  <= (I_PSEL & I_PENABLE & ~O_PREADY & ~I_PWRITE) ? rd_data : 32'h0000_0000;
            O_PSLVERR <= I_PSEL & I_PENABLE & ~O_PREADY & ~mapped;
        end
    end

    // Setting registers written at the completing access edge.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            ctrl_reg    <= `CTRL_RST;
            set_reg     <= `SET_RST;
            kfac_reg    <= `KFAC_RST;
            vctl_reg    <= `VCTL_RST;
            vup_reg     <= `VUP_RST;
            vlow_reg    <= `VLOW_RST;
            tms_reg     <= `TMS_RST;
            dt_reg      <= `DT_RST;
            hold_ms_reg <= `HOLD_RST;
            irq_en_reg  <= 4'h0;
        end else if (wr) begin
            if (hit_ctrl) ctrl_reg <= I_PWDATA[7:0];
            if (hit_set) set_reg <= I_PWDATA[15:0];
            if (hit_kfac) kfac_reg <= I_PWDATA[7:0];
            if (hit_vctl) vctl_reg <= I_PWDATA[15:0];
            if (hit_vup) vup_reg <= I_PWDATA[15:0];
            if (hit_vlow) vlow_reg <= I_PWDATA[15:0];
            if (hit_tms) tms_reg <= I_PWDATA[15:0];
            if (hit_dt) dt_reg <= I_PWDATA[15:0];
            if (hit_hold) hold_ms_reg <= I_PWDATA[15:0];
            if (hit_ien) irq_en_reg <= I_PWDATA[3:0];
        end
    end

    // Timer state, trip and interrupt flops; a new event wins over its clear.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            for (int i = 0; i < 3; i++) begin
                prog_reg[i] <= 32'h0000_0000;
                hcnt_reg[i] <= 16'h0000;
            end
            trip_reg     <= 3'h0;
            start_reg    <= 3'h0;
            irq_stat_reg <= 4'h0;
            O_TRIP_PH    <= 3'h0;
            O_TRIP       <= 1'b0;
            O_START      <= 1'b0;
            O_IRQ        <= 1'b0;
        end else begin
            prog_reg     <= prog_next;
            hcnt_reg     <= hcnt_next;
            trip_reg     <= trip_next;
            start_reg    <= above & ~{3{blocked}};
            irq_stat_reg <= irq_stat_next;
            O_TRIP_PH    <= trip_next;
            O_TRIP       <= |trip_next; // R17
            O_START      <= |(above & ~{3{blocked}});
            O_IRQ        <= |(irq_stat_next & irq_en_reg);
        end
    end

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);

    property p_plain;
        (mode == vdoc_pkg::MODE_PLAIN) |-> (pick[0] == set_reg) && (pick[2] == set_reg);
    endproperty
    a_plain: assert property (p_plain) else $error("Plain pickup differs from setting."); // R4

    property p_vctrl;
        (mode == vdoc_pkg::MODE_VCTRL && vsel[1] < vctl_reg) |-> pick[1] == kprod[23:8];
    endproperty
    a_vctrl: assert property (p_vctrl) else $error("Controlled pickup not scaled."); // R5 R6

    property p_vr_low;
        (mode == vdoc_pkg::MODE_VRESTR && vsel[0] <= vlow_reg) |-> pick[0] == kset;
    endproperty
    a_vr_low: assert property (p_vr_low) else $error("Restrained floor pickup wrong."); // R8

    property p_vr_mid;
        (mode == vdoc_pkg::MODE_VRESTR && vsel[0] > vlow_reg && vsel[0] < vup_reg && kset <= set_reg)
            |-> pick[0] >= kset && pick[0] <= set_reg;
    endproperty
    a_vr_mid: assert property (p_vr_mid) else $error("Restrained pickup out of span."); // R7 R10

    property p_block;
        blk_s2_reg |=> (O_TRIP == 1'b0) && (prog_reg[0] == 32'h0000_0000);
    endproperty
    a_block: assert property (p_block) else $error("Trip or progress while blocked."); // R15

    property p_trip;
        $rose(O_TRIP_PH[0]) |-> $past(prog_reg[0] >= `PROG_FULL) && $past(above[0]);
    endproperty
    a_trip: assert property (p_trip) else $error("Trip without completed timer."); // R17

    property p_inst;
        (!dly_rst && !above[0]) |=> prog_reg[0] == 32'h0000_0000;
    endproperty
    a_inst: assert property (p_inst) else $error("Instant reset did not clear."); // R3

    property p_hold;
        (dly_rst && !blocked && !above[0] && hcnt_reg[0] < hold_ms_reg) |=> $stable(prog_reg[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("Held progress changed."); // R14

    property p_rot;
        (xf == vdoc_pkg::XF_OFF) |-> vsel[0] == I_VAB && vsel[1] == I_VBC && vsel[2] == I_VCA;
    endproperty
    a_rot: assert property (p_rot) else $error("Phase voltage rotation wrong."); // R11 R12
endmodule
`default_nettype wire

// ### tb/voltage_dependent_overcurrent_tb_top.sv
// Self-checking bench for the voltage-dependent overcurrent element.
// Assumes the design files and the defines header are compiled first; one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "vdoc_defines.svh"
module voltage_dependent_overcurrent_tb_top;
    localparam int TICK = 4;
    logic        clk, rst, psel, penable, pwrite, blk, pready, pslverr, trip, start, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] ia, ib, ic, vab, vbc, vca;
    logic [2:0]  trip_ph;
    int          n_fail;
    int          compares;

    // Short tick keeps the timer tests brief.
    voltage_dependent_overcurrent #(.TICK_CYCLES(TICK)) dut_u (
        .I_REF_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .I_IA(ia), .I_IB(ib), .I_IC(ic), .I_VAB(vab),
        .I_VBC(vbc), .I_VCA(vca), .I_BLOCK(blk), .O_PREADY(pready), .O_PRDATA(prdata),
        .O_PSLVERR(pslverr), .O_TRIP_PH(trip_ph), .O_TRIP(trip), .O_START(start), .O_IRQ(irq));

    // Clock at 40 ns period.
    always #20 clk = ~clk;

    // Prints the verdict and stops.
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Counts one comparison and reports a mismatch.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            check(32'h0, 32'h1, "apb answer");
            conclude();
        end
    endtask

    // Register write and checked register read.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp, "read data");
        check({31'b0, e}, {31'b0, experr}, "slave error");
    endtask

    // Measurement drive at a rising edge, and settling to a falling edge.
    task automatic drive(input logic [15:0] a, b, c, x, y, z);
        @(posedge clk);
        ia <= a; ib <= b; ic <= c; vab <= x; vbc <= y; vca <= z;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // Pickup in one mode at one voltage and current.
    task automatic pick(input logic [1:0] m, input logic [15:0] v, input logic [15:0] i, input logic e);
        wr(`OFS_CTRL, {25'b0, 1'b1, 4'b0, m});
        drive(i, i, i, v, v, v);
        settle(3);
        check({31'b0, start}, {31'b0, e}, "start");
    endtask

    // Waits for trip and checks the delay in cycles.
    task automatic wait_trip(input int lo, input int hi);
        int k;
        k = 0;
        while (trip !== 1'b1 && k <= hi) begin
            @(posedge clk);
            k++;
        end
        compares++;
        if (k < lo || k > hi) begin
            n_fail++;
            $display("Error at %0t: trip after %0d cycles", $time, k);
        end
        if (k > hi) conclude();
    endtask

    // Above for five ticks, below for two, then above until trip.
    task automatic pecking(input logic [31:0] ctrl, input int lo, input int hi);
        wr(`OFS_CTRL, 32'h0000_0000);
        wr(`OFS_CTRL, ctrl);
        drive(16'h0401, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
        repeat (20) @(posedge clk);
        drive(16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
        repeat (8) @(posedge clk);
        drive(16'h0401, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
        wait_trip(lo, hi);
        drive(16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
    endtask

    // Main sequence: reset, registers, pickup, timers, block, interrupt.
    initial begin
        clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; blk = 0;
        ia = 0; ib = 0; ic = 0; vab = 0; vbc = 0; vca = 0; n_fail = 0; compares = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(`OFS_CTRL, 32'h0000_0000, 1'b0);
        rd(`OFS_SET, 32'h0000_0400, 1'b0);
        rd(`OFS_KFAC, 32'h0000_0080, 1'b0);
        rd(`OFS_VCTL, 32'h0000_8000, 1'b0);
        rd(`OFS_VUP, 32'h0000_C000, 1'b0);
        rd(`OFS_VLOW, 32'h0000_4000, 1'b0);
        rd(`OFS_TMS, 32'h0000_0064, 1'b0);
        rd(`OFS_DT, 32'h0000_03E8, 1'b0);
        rd(`OFS_HOLD, 32'h0000_0000, 1'b0);
        rd(12'h040, 32'h0000_0000, 1'b1);
        $display("test registers done");
        pick(vdoc_pkg::MODE_PLAIN, 16'h0000, 16'h0201, 1'b0);
        pick(vdoc_pkg::MODE_PLAIN, 16'h0000, 16'h0401, 1'b1);
        pick(vdoc_pkg::MODE_VCTRL, 16'h7FFF, 16'h0201, 1'b1);
        pick(vdoc_pkg::MODE_VCTRL, 16'h8000, 16'h0201, 1'b0);
        pick(vdoc_pkg::MODE_VRESTR, 16'h3000, 16'h0201, 1'b1);
        pick(vdoc_pkg::MODE_VRESTR, 16'h3000, 16'h0200, 1'b0);
        pick(vdoc_pkg::MODE_VRESTR, 16'h8000, 16'h0301, 1'b1);
        pick(vdoc_pkg::MODE_VRESTR, 16'h8000, 16'h0300, 1'b0);
        pick(vdoc_pkg::MODE_VRESTR, 16'hC000, 16'h03FF, 1'b0);
        $display("test pickup done");
        wr(`OFS_CTRL, 32'h0000_0041);
        for (int p = 0; p < 3; p++) begin
            drive(16'h0300, 16'h0300, 16'h0300, (p == 0) ? 16'h7000 : 16'hF000,
                  (p == 1) ? 16'h7000 : 16'hF000, (p == 2) ? 16'h7000 : 16'hF000);
            settle(3);
            rd(`OFS_STATUS, 32'h1 << p, 1'b0);
        end
        for (int x = 0; x < 3; x++) begin
            wr(`OFS_CTRL, 32'h0000_0041 | (x << 4));
            drive(16'h0300, 16'h0, 16'h0, 16'h7000, 16'h7000, 16'hA000);
            settle(3);
            check({31'b0, start}, (x == 1) ? 32'h0 : 32'h1, "transform start");
        end
        $display("test phases done");
        wr(`OFS_CTRL, 32'h0000_0000);
        wr(`OFS_DT, 32'h0000_0003);
        wr(`OFS_IRQ_EN, 32'h0000_000F);
        wr(`OFS_CTRL, 32'h0000_0040);
        drive(16'h0401, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
        wait_trip(8, 16);
        settle(1);
        check({29'b0, trip_ph}, 32'h1, "trip phases");
        check({31'b0, irq}, 32'h1, "irq raised");
        rd(`OFS_IRQ_STAT, 32'h0000_0009, 1'b0);
        wr(`OFS_STATUS, 32'hFFFF_FFFF);
        rd(`OFS_STATUS, 32'h0000_0009, 1'b0);
        @(posedge clk);
        blk <= 1'b1;
        settle(4);
        check({30'b0, trip, start}, 32'h0, "blocked outputs");
        rd(`OFS_STATUS, 32'h0000_0040, 1'b0);
        drive(16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
        blk <= 1'b0;
        wr(`OFS_IRQ_EN, 32'h0000_0000);
        settle(1);
        check({31'b0, irq}, 32'h0, "irq masked");
        wr(`OFS_IRQ_CLR, 32'h0000_000F);
        rd(`OFS_IRQ_STAT, 32'h0000_0000, 1'b0);
        $display("test definite block irq done");
        wr(`OFS_DT, 32'h0000_0008);
        wr(`OFS_HOLD, 32'h0000_0006);
        pecking(32'h0000_0048, 0, 20);
        pecking(32'h0000_0040, 26, 40);
        $display("test timer hold done");
        wr(`OFS_CTRL, 32'h0000_0000);
        wr(`OFS_TMS, 32'h0000_0001);
        wr(`OFS_CTRL, 32'h0000_0044);
        drive(16'h0800, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
        wait_trip(380, 440);
        $display("test inverse done");
        conclude();
    end
endmodule
`default_nettype wire
